// ---- verilog/viu_core.sv ----
// Design decision made here: the strobed register port.
`default_nettype none
module viu_core #(
  parameter int unsigned NUM_LINES = 4
) (
  // Clock and reset
  input  wire  logic        i_clock,
  input  wire  logic        i_rst_b,
  // Register port
  input  wire  logic [7:0]  i_reg_addr,
  input  wire  logic [7:0]  i_reg_wdata,
  input  wire  logic        i_reg_wr,
  input  wire  logic        i_reg_rd,
  output logic       [7:0]  o_reg_rdata,
  // Request sources
  input  wire  logic [NUM_LINES-1:0] i_port3_line,
  input  wire  logic        i_uart_tx_done,
  input  wire  logic        i_uart_rx_done,
  input  wire  logic        i_timer0_done,
  input  wire  logic        i_timer1_done,
  // Core side
  input  wire  logic        i_sample,
  input  wire  logic [15:0] i_pc_current,
  output logic              o_int_busy,
  output logic              o_pc_load,
  output logic       [15:0] o_pc_value,
  // Memory side
  output logic              o_mem_wr,
  output logic              o_mem_rd,
  output logic       [15:0] o_mem_addr,
  output logic       [7:0]  o_mem_wdata,
  input  wire  logic [7:0]  i_mem_rdata,
  // Interrupt
  output logic              o_irq
);

  localparam int unsigned NR = viu_pkg::NUM_REQ;
  localparam int unsigned SC = viu_pkg::SETUP_CYCLES;

  // ==========================================================
  // State
  typedef struct packed {
    viu_pkg::viu_state_e   state;
    logic [5:0]            cnt;
    logic [NUM_LINES-1:0]  sync1;
    logic [NUM_LINES-1:0]  sync2;
    logic [NUM_LINES-1:0]  sync3;
    logic [NUM_LINES-1:0]  line_stable;
    logic [SC-1:0][NR-1:0] hist;
    logic [7:0]            prio;
    logic [NR-1:0]         pending;
    logic [7:0]            mask;
    logic [7:0]            flags;
    logic [15:0]           sp;
    logic [2:0]            sel;
    logic [15:0]           pc_save;
    logic [15:0]           vec;
    logic [7:0]            rdata;
    logic [2:0]            evt_status;
    logic [2:0]            evt_enable;
    logic                  pc_load;
    logic [15:0]           pc_value;
    logic                  mem_wr;
    logic                  mem_rd;
    logic [15:0]           mem_addr;
    logic [7:0]            mem_wdata;
  } viu_regs_s;

  viu_regs_s state_ff;
  viu_regs_s nxt_state;

  // ==========================================================
  // Rotating priority pick: start index wins, then ascending
  function automatic logic [3:0] viu_pick(
    input logic [NR-1:0] req,
    input logic [2:0]    start
  );
    logic [3:0]  res;
    int unsigned base;
    int unsigned idx;
    res  = 4'h0;
    base = (int'(start) < NR) ? int'(start) : 0;
    for (int i = NR - 1; i >= 0; i--) begin
      idx = (base + i) % NR;
      if (req[idx]) begin
        res = {1'b1, 3'(idx)};
      end
    end
    return res;
  endfunction : viu_pick

  // ==========================================================
  // Next state
  always_comb begin
    logic [NR-1:0] hw_set;
    logic [NR-1:0] held;
    logic [NR-1:0] pend;
    logic [NUM_LINES-1:0] fall;
    logic [3:0]    pick;
    logic [5:0]    c;
    logic          grant;
    logic [2:0]    evt_new;
    logic [2:0]    evt_clr;
    hw_set  = '0;
    held    = '1;
    pend    = state_ff.pending;
    fall    = '0;
    pick    = 4'h0;
    c       = state_ff.cnt + 6'h01;
    grant   = 1'b0;
    evt_new = 3'h0;
    evt_clr = 3'h0;

    nxt_state         = state_ff;
    nxt_state.pc_load = 1'b0;
    nxt_state.mem_wr  = 1'b0;
    nxt_state.mem_rd  = 1'b0;
    nxt_state.rdata   = 8'h00;

    // Pins pass three flops; a change counts once stages 2 and 3 agree
    nxt_state.sync1 = i_port3_line;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.sync3 = state_ff.sync2;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (state_ff.sync2[i] == state_ff.sync3[i]) begin
        nxt_state.line_stable[i] = state_ff.sync3[i];
        fall[i] = state_ff.line_stable[i] & ~state_ff.sync3[i];
      end
    end

    hw_set[viu_pkg::REQ_LINE0]   = fall[0];
    hw_set[viu_pkg::REQ_LINE1]   = fall[1];
    hw_set[viu_pkg::REQ_LINE2]   = fall[2];
    hw_set[viu_pkg::REQ_LINE3]   = fall[3];
    hw_set[viu_pkg::REQ_UART_TX] = i_uart_tx_done | i_timer0_done;
    hw_set[viu_pkg::REQ_UART_RX] = fall[0] | i_uart_rx_done;
    hw_set[viu_pkg::REQ_TIMER1]  = i_timer1_done;

    // Only requests that stood the whole setup window compete
    nxt_state.hist[0] = state_ff.pending;
    for (int s = 1; s < SC; s++) begin
      nxt_state.hist[s] = state_ff.hist[s-1];
    end
    for (int s = 0; s < SC; s++) begin
      held = held & state_ff.hist[s];
    end
    pick = viu_pick(state_ff.pending & held
                    & state_ff.mask[NR-1:0],
                    state_ff.prio[2:0]);

    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        viu_pkg::ADDR_PRIORITY:   nxt_state.prio = i_reg_wdata;
        viu_pkg::ADDR_PENDING:    pend = i_reg_wdata[NR-1:0];
        viu_pkg::ADDR_MASK:       nxt_state.mask = i_reg_wdata;
        viu_pkg::ADDR_FLAGS:      nxt_state.flags = i_reg_wdata;
        viu_pkg::ADDR_SP_HIGH:    nxt_state.sp[15:8] = i_reg_wdata;
        viu_pkg::ADDR_SP_LOW:     nxt_state.sp[7:0] = i_reg_wdata;
        viu_pkg::ADDR_EVT_CLEAR:  evt_clr = i_reg_wdata[2:0];
        viu_pkg::ADDR_EVT_ENABLE: nxt_state.evt_enable = i_reg_wdata[2:0];
        default: ;
      endcase
    end

    // Register reads, data stand the next cycle only
    if (i_reg_rd) begin
      case (i_reg_addr)
        viu_pkg::ADDR_PRIORITY:   nxt_state.rdata = state_ff.prio;
        viu_pkg::ADDR_PENDING:
          nxt_state.rdata = {2'b00, state_ff.pending};
        viu_pkg::ADDR_MASK:       nxt_state.rdata = state_ff.mask;
        viu_pkg::ADDR_FLAGS:      nxt_state.rdata = state_ff.flags;
        viu_pkg::ADDR_SP_HIGH:    nxt_state.rdata = state_ff.sp[15:8];
        viu_pkg::ADDR_SP_LOW:     nxt_state.rdata = state_ff.sp[7:0];
        viu_pkg::ADDR_EVT_STATUS:
          nxt_state.rdata = {5'h00, state_ff.evt_status};
        viu_pkg::ADDR_EVT_ENABLE:
          nxt_state.rdata = {5'h00, state_ff.evt_enable};
        default:                  nxt_state.rdata = 8'h00;
      endcase
    end

    // Sequencer
    case (state_ff.state)
      viu_pkg::ST_BOOT: begin
        nxt_state.pc_load  = 1'b1;
        nxt_state.pc_value = viu_pkg::RESET_START_ADDR;
        nxt_state.state    = viu_pkg::ST_IDLE;
      end
      viu_pkg::ST_IDLE: begin
        grant = i_sample & state_ff.mask[viu_pkg::MASK_GLOBAL_BIT]
                & pick[3];
        if (grant) begin
          nxt_state.state   = viu_pkg::ST_STACK;
          nxt_state.cnt     = 6'h01;
          nxt_state.sel     = pick[2:0];
          nxt_state.pc_save = i_pc_current;
          nxt_state.mask[viu_pkg::MASK_GLOBAL_BIT] = 1'b0;
          pend[pick[2:0]]   = 1'b0;
          evt_new[viu_pkg::EVT_GRANT] = 1'b1;
        end
      end
      viu_pkg::ST_STACK: begin
        nxt_state.cnt = c;
        // Push order matches the return path: flags pop first
        if (c == viu_pkg::PUSH_PCL_CYCLE || c == viu_pkg::PUSH_PCH_CYCLE
            || c == viu_pkg::PUSH_FLG_CYCLE) begin
          nxt_state.sp       = state_ff.sp - 16'h0001;
          nxt_state.mem_wr   = 1'b1;
          nxt_state.mem_addr = state_ff.sp - 16'h0001;
          if (c == viu_pkg::PUSH_PCL_CYCLE) begin
            nxt_state.mem_wdata = state_ff.pc_save[7:0];
          end else if (c == viu_pkg::PUSH_PCH_CYCLE) begin
            nxt_state.mem_wdata = state_ff.pc_save[15:8];
          end else begin
            nxt_state.mem_wdata = state_ff.flags;
          end
        end
        if (c == viu_pkg::PUSH_FLG_CYCLE) begin
          nxt_state.state = viu_pkg::ST_VECTOR;
        end
      end
      viu_pkg::ST_VECTOR: begin
        nxt_state.cnt = c;
        if (c == viu_pkg::VEC_HI_RD_CYCLE) begin
          nxt_state.mem_rd   = 1'b1;
          nxt_state.mem_addr = viu_pkg::VECTOR_TABLE_BASE
                               + {12'h000, state_ff.sel, 1'b0};
        end
        if (c == viu_pkg::VEC_LO_RD_CYCLE) begin
          nxt_state.mem_rd   = 1'b1;
          nxt_state.mem_addr = viu_pkg::VECTOR_TABLE_BASE
                               + {12'h000, state_ff.sel, 1'b1};
        end
        if (state_ff.cnt == viu_pkg::VEC_HI_RD_CYCLE + 6'h01) begin
          nxt_state.vec[15:8] = i_mem_rdata;
        end
        if (state_ff.cnt == viu_pkg::VEC_LO_RD_CYCLE + 6'h01) begin
          nxt_state.vec[7:0] = i_mem_rdata;
        end
        if (c == viu_pkg::LAUNCH_CNT) begin
          nxt_state.pc_load  = 1'b1;
          nxt_state.pc_value = state_ff.vec;
          nxt_state.state    = viu_pkg::ST_IDLE;
          nxt_state.cnt      = 6'h00;
          evt_new[viu_pkg::EVT_LAUNCH] = 1'b1;
        end
      end
      default: begin
        nxt_state.state = viu_pkg::ST_IDLE;
        nxt_state.cnt   = 6'h00;
      end
    endcase

    // Hardware set beats software write and grant clear
    evt_new[viu_pkg::EVT_OVERRUN] = |(hw_set & state_ff.pending);
    nxt_state.pending = pend | hw_set;
    nxt_state.evt_status = (state_ff.evt_status & ~evt_clr) | evt_new;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_ff             <= '0;
      state_ff.state       <= viu_pkg::ST_BOOT;
      state_ff.prio        <= viu_pkg::RST_PRIORITY;
      state_ff.pending     <= viu_pkg::RST_PENDING;
      state_ff.mask        <= viu_pkg::RST_MASK;
      state_ff.flags       <= viu_pkg::RST_FLAGS;
      state_ff.sp          <= viu_pkg::RST_SP;
      state_ff.evt_enable  <= viu_pkg::RST_EVT_ENABLE;
      state_ff.line_stable <= '1;
      state_ff.sync1       <= '1;
      state_ff.sync2       <= '1;
      state_ff.sync3       <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  assign o_reg_rdata = state_ff.rdata;
  assign o_int_busy  = (state_ff.state == viu_pkg::ST_STACK)
                       || (state_ff.state == viu_pkg::ST_VECTOR);
  assign o_pc_load   = state_ff.pc_load;
  assign o_pc_value  = state_ff.pc_value;
  assign o_mem_wr    = state_ff.mem_wr;
  assign o_mem_rd    = state_ff.mem_rd;
  assign o_mem_addr  = state_ff.mem_addr;
  assign o_mem_wdata = state_ff.mem_wdata;
  assign o_irq       = |(state_ff.evt_status & state_ff.evt_enable);

endmodule : viu_core
`default_nettype wire

// ---- verilog/viu_pkg.sv ----
`default_nettype none
package viu_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_PRIORITY   = 8'hf9;
  localparam logic [7:0] ADDR_PENDING    = 8'hfa;
  localparam logic [7:0] ADDR_MASK       = 8'hfb;
  localparam logic [7:0] ADDR_FLAGS      = 8'hfc;
  localparam logic [7:0] ADDR_SP_HIGH    = 8'hfe;
  localparam logic [7:0] ADDR_SP_LOW     = 8'hff;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'he0;
  localparam logic [7:0] ADDR_EVT_CLEAR  = 8'he1;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'he2;

  // ==========================================================
  // Values after reset
  localparam logic [7:0]  RST_PRIORITY   = 8'h00;
  localparam logic [5:0]  RST_PENDING    = 6'h00;
  localparam logic [7:0]  RST_MASK       = 8'h00;
  localparam logic [7:0]  RST_FLAGS      = 8'h00;
  localparam logic [15:0] RST_SP         = 16'h0000;
  localparam logic [2:0]  RST_EVT_ENABLE = 3'h0;

  // ==========================================================
  // Field positions
  localparam int unsigned NUM_REQ         = 6;
  localparam int unsigned MASK_GLOBAL_BIT = 7;
  localparam int unsigned EVT_GRANT       = 0;
  localparam int unsigned EVT_LAUNCH      = 1;
  localparam int unsigned EVT_OVERRUN     = 2;
  localparam int unsigned REQ_LINE0       = 3;
  localparam int unsigned REQ_LINE1       = 2;
  localparam int unsigned REQ_LINE2       = 0;
  localparam int unsigned REQ_LINE3       = 1;
  localparam int unsigned REQ_UART_RX     = 3;
  localparam int unsigned REQ_UART_TX     = 4;
  localparam int unsigned REQ_TIMER0      = 4;
  localparam int unsigned REQ_TIMER1      = 5;

  // ==========================================================
  // Program memory layout
  localparam logic [15:0] VECTOR_TABLE_BASE  = 16'h0000;
  localparam logic [15:0] VECTOR_TABLE_BYTES = 16'h000c;
  localparam logic [15:0] RESET_START_ADDR   = 16'h000c;

  // ==========================================================
  // Timing, in core clock periods and derived cycles
  localparam int unsigned CORE_PERIOD_NS   = 25;
  localparam int unsigned CLOCK_PERIOD_NS  = 25;
  localparam int unsigned CORE_CYCLES      =
    (CORE_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned SETUP_CORE_PERIODS = 5;
  localparam int unsigned SETUP_CYCLES = SETUP_CORE_PERIODS * CORE_CYCLES;
  localparam int unsigned STACK_PHASE_CYCLES  = 48 * CORE_CYCLES;
  localparam int unsigned VECTOR_PHASE_CYCLES = 9 * CORE_CYCLES;
  localparam int unsigned LAUNCH_CYCLE        = 58 * CORE_CYCLES;
  localparam logic [5:0] PUSH_PCL_CYCLE = 6'(STACK_PHASE_CYCLES - 2);
  localparam logic [5:0] PUSH_PCH_CYCLE = 6'(STACK_PHASE_CYCLES - 1);
  localparam logic [5:0] PUSH_FLG_CYCLE = 6'(STACK_PHASE_CYCLES);
  localparam logic [5:0] VEC_HI_RD_CYCLE = 6'(STACK_PHASE_CYCLES + 2);
  localparam logic [5:0] VEC_LO_RD_CYCLE = 6'(STACK_PHASE_CYCLES + 5);
  localparam logic [5:0] LAUNCH_CNT     = 6'(LAUNCH_CYCLE);

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_BOOT   = 2'b00,
    ST_IDLE   = 2'b01,
    ST_STACK  = 2'b10,
    ST_VECTOR = 2'b11
  } viu_state_e;

endpackage : viu_pkg
`default_nettype wire

// ---- dv/viu_core_sva.sv ----
`default_nettype none
module viu_core_sva (
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        o_int_busy,
  input wire logic        o_pc_load,
  input wire logic [15:0] o_pc_value,
  input wire logic        o_mem_wr,
  input wire logic        o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0]  i_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Grant sequence steps
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_push;
    o_mem_wr ##1 o_mem_wr ##1 o_mem_wr;
  endsequence
  sequence s_fetch;
    o_mem_rd ##3 o_mem_rd;
  endsequence
  a_boot_start: assert property (
    $rose(i_rst_b) |-> ##[1:3] (o_pc_load && o_pc_value == 16'h000c))
    else $error("reset start address wrong");
  a_push_time: assert property (
    $rose(o_int_busy) |-> ##45 s_push)
    else $error("stack pushes not at cycles 46 to 48");
  a_fetch_time: assert property (
    $rose(o_int_busy) |-> ##49 s_fetch)
    else $error("vector reads not at cycles 50 and 53");
  a_launch_time: assert property (
    $rose(o_int_busy) |-> ##57 o_pc_load)
    else $error("service launch not at cycle 58");
  a_busy_ends: assert property (
    $fell(o_int_busy) |-> o_pc_load)
    else $error("busy dropped without a launch");
  a_stack_down: assert property (
    o_mem_wr && $past(o_mem_wr) |-> o_mem_addr == $past(o_mem_addr) - 16'h1)
    else $error("stack address not descending");
  a_vec_range: assert property (
    o_mem_rd |-> o_mem_addr < 16'h000c)
    else $error("vector read outside table");
  a_vec_pair: assert property (
    s_fetch |-> o_mem_addr[0] && o_mem_addr == $past(o_mem_addr, 3) + 16'h1)
    else $error("vector bytes not consecutive");
  a_launch_vec: assert property (
    o_pc_load && $past(o_int_busy) |->
      o_pc_value == {$past(i_mem_rdata, 7), $past(i_mem_rdata, 4)})
    else $error("launch address not the fetched vector");
endmodule : viu_core_sva

bind viu_core viu_core_sva u_sva (
  .i_clock    (i_clock),
  .i_rst_b    (i_rst_b),
  .o_int_busy (o_int_busy),
  .o_pc_load  (o_pc_load),
  .o_pc_value (o_pc_value),
  .o_mem_wr   (o_mem_wr),
  .o_mem_rd   (o_mem_rd),
  .o_mem_addr (o_mem_addr),
  .i_mem_rdata(i_mem_rdata)
);
`default_nettype wire

// ---- dv/viu_mem_model.sv ----
`default_nettype none
module viu_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_mem_rd,
  input  wire logic [15:0] i_mem_addr,
  output logic      [7:0]  o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_mem_rdata = 8'h00;
  // Idle cycles show the inverse, so a late sample is caught
  always @(posedge i_clock) begin
    if (i_mem_rd) begin
      o_mem_rdata <= i_mem_addr[7:0] ^ 8'h5a;
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
endmodule : viu_mem_model
`default_nettype wire

// ---- dv/vectored_interrupt_unit_tb.sv ----
`default_nettype none
module vectored_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst_b, i_reg_wr, i_reg_rd, i_sample, o_irq;
  logic i_uart_tx_done, i_uart_rx_done, i_timer0_done, i_timer1_done;
  logic o_int_busy, o_pc_load, o_mem_wr, o_mem_rd;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_mem_rdata;
  logic [7:0] o_mem_wdata, rd;
  logic [3:0] i_port3_line;
  logic [15:0] i_pc_current, o_pc_value, o_mem_addr;
  int miscompares, checked;
  localparam logic [7:0] RW_REGS [6] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc,
                                         8'hfe, 8'hff};
  localparam int SRC_BIT [8] = '{3, 2, 0, 1, 4, 3, 4, 5};

  viu_core u_dut (.i_clock, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_port3_line, .i_uart_tx_done,
    .i_uart_rx_done, .i_timer0_done, .i_timer1_done, .i_sample,
    .i_pc_current, .o_int_busy, .o_pc_load, .o_pc_value, .o_mem_wr,
    .o_mem_rd, .o_mem_addr, .o_mem_wdata, .i_mem_rdata, .o_irq);
  viu_mem_model u_mem (.i_clock(i_clock), .i_mem_rd(o_mem_rd),
    .i_mem_addr(o_mem_addr), .o_mem_rdata(i_mem_rdata));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(logic [7:0] a);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1 rd = o_reg_rdata;
  endtask : rdr
  function automatic int pick(logic [2:0] start, logic [5:0] req);
    int s;
    s = (start > 3'd5) ? 0 : int'(start);
    for (int k = 0; k < 6; k++) begin
      if (req[(s + k) % 6]) return (s + k) % 6;
    end
    return -1;
  endfunction : pick

  // ==========================================================
  // Scenarios
  task automatic t_boot();
    for (int k = 0; k < 6 && o_pc_load !== 1'b1; k++) begin
      @(posedge i_clock);
      #1;
    end
    if (o_pc_load !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    chk("start address", 16'h000c, o_pc_value);
    $display("boot done");
  endtask : t_boot
  task automatic t_regs();
    foreach (RW_REGS[i]) begin
      rdr(RW_REGS[i]);
      chk("reset value", 16'h0000, {8'h00, rd});
      wr(RW_REGS[i], 8'hff);
      rdr(RW_REGS[i]);
      chk("readback", (i == 1) ? 16'h3f : 16'hff, {8'h00, rd});
      wr(RW_REGS[i], 8'h00);
    end
    rdr(8'h10);
    chk("unmapped read", 16'h0000, {8'h00, rd});
    $display("registers done");
  endtask : t_regs
  task automatic t_sources();
    for (int s = 0; s < 8; s++) begin
      wr(8'hfa, 8'h00);
      @(posedge i_clock);
      if (s < 4) i_port3_line[s] <= 1'b0;
      else {i_timer1_done, i_timer0_done, i_uart_rx_done, i_uart_tx_done}
             <= 4'(1 << (s - 4));
      @(posedge i_clock);
      {i_timer1_done, i_timer0_done, i_uart_rx_done, i_uart_tx_done} <= '0;
      rd = 8'h00;
      for (int k = 0; k < 12 && rd == 8'h00; k++) rdr(8'hfa);
      @(posedge i_clock);
      i_port3_line <= 4'hf;
      chk("pending", 16'(1 << SRC_BIT[s]), {8'h00, rd});
    end
    $display("sources done");
  endtask : t_sources
  task automatic t_grant(logic [7:0] prio, logic [7:0] pend, logic [5:0] en);
    int sel;
    logic [15:0] pc;
    sel = pick(prio[2:0], pend[5:0] & en);
    pc = 16'h1234 + 16'(sel);
    // Stale requests from earlier scenarios would win the grant
    wr(8'hfa, 8'h00);
    wr(8'hf9, prio);
    wr(8'hfb, {2'b10, en});
    wr(8'hfe, 8'h01);
    wr(8'hff, 8'h00);
    wr(8'hfc, 8'h5a);
    wr(8'hfa, pend);
    // Sample right after the write: too fresh to be taken
    i_sample <= 1'b1;
    @(posedge i_clock);
    i_sample <= 1'b0;
    #1 chk("early sample", 16'h0, {15'h0, o_int_busy});
    repeat (6) @(posedge i_clock);
    i_sample <= 1'b1;
    i_pc_current <= pc;
    for (int c = 1; c <= 58; c++) begin
      @(posedge i_clock);
      i_sample <= 1'b0;
      #1;
      if (c == 1) chk("busy", 16'(sel >= 0), {15'h0, o_int_busy});
      if (sel < 0) break;
      if (c >= 46 && c <= 48) begin
        chk("push addr", 16'h0100 - 16'(c - 45), o_mem_addr);
        chk("push data", {8'h01, (c == 46) ? pc[7:0] : (c == 47) ?
            pc[15:8] : 8'h5a}, {7'h0, o_mem_wr, o_mem_wdata});
      end
      if (c == 50 || c == 53)
        chk("vector read", 16'(2 * sel + c / 53),
            o_mem_rd ? o_mem_addr : 16'hffff);
      if (c == 58)
        chk("launch", {8'(2 * sel) ^ 8'h5a, 8'(2 * sel + 1) ^ 8'h5a},
            o_pc_load ? o_pc_value : 16'hffff);
    end
    rdr(8'hfa);
    chk("pending after", 16'(pend[5:0] & ~(sel >= 0 ? 6'(1 << sel) : 6'h0)),
        {8'h00, rd});
    rdr(8'hfb);
    chk("mask after", {8'h00, sel < 0, 1'b0, en}, {8'h00, rd});
    $display("grant done, priority %h", prio);
  endtask : t_grant
  task automatic t_irq();
    wr(8'hfa, 8'h00);
    wr(8'he1, 8'h07);
    t_grant(8'h00, 8'h01, 6'h01);
    rdr(8'he0);
    chk("event status", 16'h0003, {8'h00, rd});
    chk("irq masked", 16'h0, {15'h0, o_irq});
    wr(8'he2, 8'h01);
    #1 chk("irq raised", 16'h1, {15'h0, o_irq});
    wr(8'he1, 8'h01);
    #1 chk("irq cleared", 16'h0, {15'h0, o_irq});
    // Second set on a still pending request marks an overrun
    @(posedge i_clock);
    i_uart_rx_done <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_uart_rx_done <= 1'b0;
    rdr(8'he0);
    chk("overrun event", 16'h0006, {8'h00, rd});
    $display("interrupt done");
  endtask : t_irq

  initial begin
    {i_rst_b, i_reg_wr, i_reg_rd, i_sample, i_reg_addr, i_reg_wdata} = '0;
    {i_uart_tx_done, i_uart_rx_done, i_timer0_done, i_timer1_done} = '0;
    i_port3_line = 4'hf;
    i_pc_current = 16'h0000;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_boot();
    t_regs();
    t_sources();
    t_grant(8'h00, 8'h3f, 6'h3f);
    t_grant(8'h03, 8'h21, 6'h3f);
    t_grant(8'h06, 8'h30, 6'h3f);
    t_grant(8'h02, 8'h05, 6'h3b);
    t_grant(8'h01, 8'h0e, 6'h3f);
    t_grant(8'h05, 8'h3f, 6'h00);
    t_irq();
    finish_test();
  end
endmodule : vectored_interrupt_unit_tb
`default_nettype wire
